/* File: src/isa_bus_master_request_grant.sv */
// Bus ownership request and grant logic of the alternate master
// Assumes bus pins arrive asynchronously and the user side is on clk
`timescale 1ns/10ps
`include "isa_master_params.svh"

module isa_bus_master_request_grant
    import isa_master_pkg::*;
#(
    parameter int NUM_CH = `NUM_CHANNELS
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [1:0] channel_sel,
    input wire logic xfer_need,
    input wire logic xfer_start,
    input wire logic xfer_write,
    input wire logic [23:0] xfer_addr,
    input wire logic [15:0] xfer_wdata,
    output logic xfer_done,
    output logic [15:0] xfer_rdata,
    output logic bus_owned,
    input wire logic [9:0] io_base,
    output logic io_read_hit,
    output logic io_write_hit,
    output logic [3:0] latched_addr_hi,
    output logic [3:0] dma_request,
    output logic [3:0] dma_request_oe,
    input wire logic [3:0] dma_grant_n,
    input wire logic refresh_n,
    output logic master_n_o,
    output logic master_n_oe,
    input wire logic io_addr_qualifier_n,
    input wire logic addr_latch_strobe,
    input wire logic io_read_strobe_n,
    input wire logic io_write_strobe_n,
    input wire logic channel_ready,
    input wire logic [23:0] addr_i,
    output logic [23:0] addr_o,
    output logic addr_oe,
    input wire logic [15:0] data_i,
    output logic [15:0] data_o,
    output logic data_oe,
    output logic high_byte_enable_n,
    output logic mem_read_n,
    output logic mem_write_n,
    output logic ctrl_oe
);

    // =====================================================
    // Reset release and input synchronisers
    logic [1:0] rst_sync_r;
    logic rst_n;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) rst_sync_r <= 2'h0;
        else rst_sync_r <= {rst_sync_r[0], 1'h1};
    end
    assign rst_n = rst_sync_r[1];

    localparam int SW = 10;
    logic [SW-1:0] s1_r, s2_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= 10'h3FF;
            s2_r <= 10'h3FF;
        end else begin
            s1_r <= {dma_grant_n, refresh_n, io_addr_qualifier_n, addr_latch_strobe,
                     io_read_strobe_n, io_write_strobe_n, channel_ready};
            s2_r <= s1_r;
        end
    end
    logic [3:0] grant_n_s;
    logic refresh_n_s, qual_n_s, ale_s, ior_n_s, iow_n_s, ready_s;
    assign {grant_n_s, refresh_n_s, qual_n_s, ale_s, ior_n_s, iow_n_s, ready_s} = s2_r;

    // Address and data pins pass the same two stages as the strobes
    logic [23:0] addr_s1_r, addr_s2_r;
    logic [15:0] data_s1_r, data_s2_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_s1_r <= 24'h000000;
            addr_s2_r <= 24'h000000;
            data_s1_r <= 16'h0000;
            data_s2_r <= 16'h0000;
        end else begin
            addr_s1_r <= addr_i;
            addr_s2_r <= addr_s1_r;
            data_s1_r <= data_i;
            data_s2_r <= data_s1_r;
        end
    end

    // =====================================================
    // Upper address latch
    logic [3:0] la_hi_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            la_hi_r <= 4'h0;
        end else begin
            if (ale_s) la_hi_r <= addr_s2_r[23:20];
        end
    end
    assign latched_addr_hi = la_hi_r;

    // =====================================================
    // Slave strobe qualification
    logic io_match;
    assign io_match = !qual_n_s && (addr_s2_r[9:`IO_SPAN_BITS] == io_base[9:`IO_SPAN_BITS]);
    logic io_rd_r, io_wr_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            io_rd_r <= 1'h0;
            io_wr_r <= 1'h0;
        end else begin
            io_rd_r <= io_match && !ior_n_s && !bus_owned;
            io_wr_r <= io_match && !iow_n_s && !bus_owned;
        end
    end
    assign io_read_hit = io_rd_r;
    assign io_write_hit = io_wr_r;

    // =====================================================
    // Ownership state machine
    own_state_t state_r;
    logic [1:0] ch_r;
    logic [7:0] gap_r, gap_len_r;
    logic cyc_r, done_r;
    logic [15:0] rdata_r;
    logic grant_seen;
    assign grant_seen = !grant_n_s[ch_r] && refresh_n_s;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            ch_r <= 2'h0;
            gap_r <= 8'h00;
            gap_len_r <= `GAP_MIN_CYCLES;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    ch_r <= channel_sel;
                    if (xfer_need) state_r <= ST_REQ;
                end
                ST_REQ: begin
                    if (!xfer_need) state_r <= ST_IDLE;
                    else if (grant_seen) state_r <= ST_OWN;
                end
                ST_OWN: begin
                    if (!xfer_need && !cyc_r) state_r <= ST_RELEASE;
                end
                ST_RELEASE: begin
                    gap_r <= gap_len_r;
                    state_r <= ST_GAP;
                end
                ST_GAP: begin
                    if (gap_r != 8'h00) gap_r <= gap_r - 8'h01;
                    else state_r <= ST_IDLE;
                end
                default: state_r <= ST_IDLE;
            endcase
            // Gap shrinks on each grant down to GAP_MIN_CYCLES and grows up to GAP_MAX_CYCLES when another master holds the line
            if (state_r == ST_REQ && grant_seen && xfer_need) begin
                if (gap_len_r > `GAP_MIN_CYCLES) gap_len_r <= gap_len_r - `GAP_STEP;
            end else if (state_r == ST_IDLE && xfer_need && !grant_n_s[channel_sel]) begin
                if (gap_len_r < `GAP_MAX_CYCLES) gap_len_r <= gap_len_r + `GAP_STEP;
            end
        end
    end

    assign bus_owned = (state_r == ST_OWN);

    // =====================================================
    // Master bus cycles
    logic [23:0] addr_r;
    logic [15:0] wdata_r;
    logic wr_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cyc_r <= 1'h0;
            done_r <= 1'h0;
            rdata_r <= 16'h0000;
            addr_r <= 24'h000000;
            wdata_r <= 16'h0000;
            wr_r <= 1'h0;
        end else begin
            done_r <= 1'h0;
            if (bus_owned && !cyc_r && xfer_start) begin
                cyc_r <= 1'h1;
                addr_r <= xfer_addr;
                wdata_r <= xfer_wdata;
                wr_r <= xfer_write;
            end else if (cyc_r && ready_s) begin
                cyc_r <= 1'h0;
                done_r <= 1'h1;
                if (!wr_r) rdata_r <= data_s2_r;
            end
        end
    end
    assign xfer_done = done_r;
    assign xfer_rdata = rdata_r;

    // =====================================================
    // Pin drive
    always_comb begin
        dma_request = 4'h0;
        dma_request[ch_r] = (state_r == ST_REQ);
    end
    assign dma_request_oe = 4'hF;
    assign master_n_o = 1'h0;
    assign master_n_oe = bus_owned;
    assign addr_o = addr_r;
    assign addr_oe = bus_owned;
    assign ctrl_oe = bus_owned;
    assign data_o = wdata_r;
    assign data_oe = bus_owned && cyc_r && wr_r;
    assign high_byte_enable_n = !(bus_owned && cyc_r);
    assign mem_read_n = !(cyc_r && !wr_r);
    assign mem_write_n = !(cyc_r && wr_r);

    // =====================================================
    // Assertions
    sequence granted_s;
        state_r == ST_REQ && xfer_need && grant_seen;
    endsequence
    own_after_grant_a: assert property (@(posedge clk) disable iff (!rst_n)
        granted_s |=> master_n_oe) else $error("ownership not taken on grant");
    refresh_blocks_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state_r == ST_REQ && !refresh_n_s) |=> !master_n_oe) else $error("grant during refresh");
    req_held_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state_r == ST_REQ && xfer_need && !grant_seen) |=> dma_request[ch_r])
        else $error("request dropped before grant");
    req_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
        (bus_owned && !xfer_need && !cyc_r) |=> dma_request == 4'h0) else $error("request stays");
    gap_between_a: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(bus_owned) |-> (dma_request == 4'h0) [*4]) else $error("no gap");
    drive_owned_a: assert property (@(posedge clk) disable iff (!rst_n)
        (addr_oe || data_oe || ctrl_oe) |-> master_n_oe) else $error("drive without ownership");
    hbe_driven_a: assert property (@(posedge clk) disable iff (!rst_n)
        cyc_r |-> (!high_byte_enable_n && ctrl_oe)) else $error("high byte not enabled");
    stretch_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cyc_r && !ready_s) |=> cyc_r) else $error("cycle not stretched");
    float_first_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(|dma_request) |-> !master_n_oe && !addr_oe) else $error("request while driving");
    strobe_qual_a: assert property (@(posedge clk) disable iff (!rst_n)
        io_read_hit |-> $past(!qual_n_s)) else $error("read hit without qualifier");

endmodule // isa_bus_master_request_grant

/* File: inc/isa_master_params.svh */
// Constants for the expansion bus ownership block
// Assumes inclusion by the design file only
`ifndef ISA_MASTER_PARAMS_SVH
`define ISA_MASTER_PARAMS_SVH
`define NUM_CHANNELS 4
`define CH_SEL_W 2
`define ADDR_W 24
`define IO_ADDR_W 10
`define IO_BASE_RESET 10'h300
`define IO_SPAN_BITS 4
`define GAP_MIN_CYCLES 8'h04
`define GAP_MAX_CYCLES 8'h40
`define GAP_STEP 8'h04
`endif

/* File: inc/isa_master_pkg.sv */
// Types for the expansion bus ownership block
// Assumes the params header is reachable by bare name
package isa_master_pkg;
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_REQ = 5'h02,
        ST_OWN = 5'h04,
        ST_RELEASE = 5'h08,
        ST_GAP = 5'h10
    } own_state_t;
endpackage

/* File: tb/host_master_model.sv */
// Host permanent master model: channel grant and ready
// Assumes requests and strobes of the block change on clk
`timescale 1ns/10ps
module host_master_model (
    input wire logic clk,
    input wire logic [3:0] dma_request,
    input wire logic master_n_oe,
    input wire logic mem_read_n,
    input wire logic mem_write_n,
    input wire logic [3:0] stretch,
    output logic [3:0] dma_grant_n,
    output logic channel_ready
);
    // ====
    // Grant follows request and holds through ownership
    logic [3:0] held = 4'h0;
    int cnt = 0;
    initial dma_grant_n = 4'hF;
    initial channel_ready = 1'b1;
    always @(negedge clk) begin
        if (dma_request !== 4'h0) held <= dma_request;
        dma_grant_n <= ~(dma_request | (master_n_oe ? held : 4'h0));
        if (mem_read_n === 1'b0 || mem_write_n === 1'b0) cnt <= cnt + 1;
        else cnt <= 0;
        channel_ready <= (cnt > stretch);
    end
endmodule // host_master_model

/* File: tb/tb_top.sv */
// Testbench of the bus ownership block
// Assumes the host model answers requests and strobes
`timescale 1ns/10ps
module tb_top;
    logic clk = 0, resetn = 0, xfer_need = 0, xfer_start = 0, xfer_write = 0;
    logic refresh_n = 1, io_addr_qualifier_n = 1, addr_latch_strobe = 0;
    logic io_read_strobe_n = 1, io_write_strobe_n = 1, hbe_seen = 0;
    logic [1:0] channel_sel = 0;
    logic [23:0] xfer_addr = 0, addr_i = 0, addr_o;
    logic [15:0] xfer_wdata = 0, data_i = 0, data_o, xfer_rdata;
    logic [9:0] io_base = 10'h300;
    logic [3:0] dma_request, dma_request_oe, dma_grant_n, latched_addr_hi, stretch = 0;
    logic xfer_done, bus_owned, io_read_hit, io_write_hit, master_n_o, master_n_oe;
    logic channel_ready, addr_oe, data_oe, high_byte_enable_n, mem_read_n, mem_write_n;
    logic ctrl_oe;
    logic [16:0] expq[$];
    logic [16:0] e;
    logic [31:0] rng = 32'h43;
    int mismatches = 0, checks = 0, n = 0;
    always #20 clk = ~clk;
    isa_bus_master_request_grant i_isa_bus_master_request_grant (.clk, .resetn,
        .channel_sel, .xfer_need, .xfer_start, .xfer_write, .xfer_addr, .xfer_wdata,
        .xfer_done, .xfer_rdata, .bus_owned, .io_base, .io_read_hit, .io_write_hit,
        .latched_addr_hi, .dma_request, .dma_request_oe, .dma_grant_n, .refresh_n,
        .master_n_o, .master_n_oe, .io_addr_qualifier_n, .addr_latch_strobe,
        .io_read_strobe_n, .io_write_strobe_n, .channel_ready, .addr_i, .addr_o,
        .addr_oe, .data_i, .data_o, .data_oe, .high_byte_enable_n, .mem_read_n,
        .mem_write_n, .ctrl_oe);
    host_master_model i_host_master_model (.clk, .dma_request, .master_n_oe,
        .mem_read_n, .mem_write_n, .stretch, .dma_grant_n, .channel_ready);
    // ====
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    function automatic logic cond(input int w);
        case (w)
            0: return dma_request[channel_sel];
            1: return bus_owned;
            2: return !bus_owned;
            default: return xfer_done;
        endcase
    endfunction
    task automatic wait_for(input int w);
        n = 0;
        while (cond(w) !== 1'b1) begin
            @(negedge clk);
            n++;
            if (high_byte_enable_n === 1'b0) hbe_seen = 1;
            if (n > 300) begin
                mismatches++;
                tally_and_finish();
            end
        end
    endtask
    // ====
    // Read and write data monitor
    always @(negedge clk) begin
        if (xfer_done === 1'b1) begin
            if (expq.size() == 0) check(24'h1, 24'h0);
            else begin
                e = expq.pop_front();
                if (e[16]) check(data_o, e[15:0]);
                else check(xfer_rdata, e[15:0]);
            end
        end
    end
    // ====
    // Main sequence
    initial begin
        repeat (3) @(negedge clk);
        resetn = 1;
        check({dma_request, addr_oe, data_oe, ctrl_oe, master_n_oe}, 24'h0);
        repeat (3) @(negedge clk);
        for (int c = 0; c < 4; c++) begin
            channel_sel = c[1:0];
            stretch = 4'(c * 3);
            xfer_write = c[0];
            xfer_need = 1;
            wait_for(0);
            check(dma_request, 4'h1 << c);
            if (c > 0) check(n > 4, 1'b1);
            wait_for(1);
            check({master_n_oe, addr_oe, ctrl_oe, dma_request_oe[c]}, 4'hF);
            check(master_n_o, 1'b0);
            rng = xs(rng);
            data_i = rng[15:0];
            xfer_wdata = rng[15:0];
            expq.push_back({c[0], rng[15:0]});
            xfer_addr = rng[31:8];
            xfer_start = 1;
            @(negedge clk);
            xfer_start = 0;
            check(addr_o, xfer_addr);
            check({mem_write_n, mem_read_n, data_oe}, xfer_write ? 3'h3 : 3'h4);
            hbe_seen = 0;
            wait_for(3);
            check(n >= stretch, 1'b1);
            check(hbe_seen, 1'b1);
            xfer_need = 0;
            wait_for(2);
            repeat (2) @(negedge clk);
            check({addr_oe, data_oe, ctrl_oe, master_n_oe, dma_request[c]}, 24'h0);
        end
        refresh_n = 0;
        xfer_need = 1;
        repeat (20) @(negedge clk);
        check(bus_owned, 1'b0);
        refresh_n = 1;
        wait_for(1);
        xfer_need = 0;
        wait_for(2);
        for (int k = 0; k < 8; k++) begin
            io_addr_qualifier_n = k[0];
            addr_i = k[1] ? 24'h30A : 24'h28A;
            io_read_strobe_n = !k[2];
            io_write_strobe_n = k[2];
            repeat (4) @(negedge clk);
            check({io_read_hit, io_write_hit},
                (!k[0] && k[1]) ? (k[2] ? 2'h2 : 2'h1) : 2'h0);
            io_read_strobe_n = 1;
            io_write_strobe_n = 1;
            repeat (3) @(negedge clk);
        end
        addr_i = 24'hA00000;
        addr_latch_strobe = 1;
        repeat (3) @(negedge clk);
        addr_latch_strobe = 0;
        repeat (3) @(negedge clk);
        addr_i = 24'h500000;
        repeat (3) @(negedge clk);
        check(latched_addr_hi, 4'hA);
        tally_and_finish();
    end
endmodule // tb_top
